// *** logic/irq_ctrl.sv ***
// interrupt controller: trap, four external lines, peripheral flags,
// fixed priority, vectors, global mask and halt wakeup decisions.
// assumes an 8-bit register port with read data one cycle after the
// read strobe, and a core that acks the request shown on its outputs.
`timescale 1ns/100ps
module irq_ctrl (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // register port
  input ic_pkg::reg_req_s reg_req,
  output logic [7:0] rdata,
  // processor core
  input ic_pkg::core_in_s core_in,
  output ic_pkg::core_out_s core_out,
  // port pins and their interrupt input configuration
  input wire [7:0] port_a,
  input wire [6:0] port_b,
  input wire [7:0] pin_cfg_a,
  input wire [6:0] pin_cfg_b,
  // peripheral flag events
  input wire [13:0] periph_set,
  input wire [13:0] periph_clr
);
  import ic_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sense; // ext_irq_sense_ctrl
    logic [7:0] pinsel; // ext_irq_pin_select
    logic [13:0] en; // peripheral enables
    logic [13:0] flag; // peripheral request latches
    logic [13:0] armed; // status read seen with flag set
    logic trap; // trap waiting for its ack
    logic mask; // global mask bit
    logic [7:0] rdata; // read data
    core_out_s out; // outputs towards the core
  } ctrl_s;

  ctrl_s q;
  ctrl_s d;

  // ----------------------------------------------------------------
  // external lines
  // ----------------------------------------------------------------
  logic [3:0] grp_pin [NLINE]; // pins of each line's group
  logic [3:0] grp_cfg [NLINE]; // which of them are interrupt inputs
  logic [NLINE-1:0] line_lvl; // resulting line level
  logic [NLINE-1:0] line_clr; // clear of a line's latch
  logic [NLINE-1:0] line_req; // request of each line
  logic [NLINE-1:0] sense_chg; // sensitivity field changed

  // pin groups; line3 has three pins, its fourth slot stays high
  always_comb begin
    grp_pin[0] = port_a[3:0];
    grp_cfg[0] = pin_cfg_a[3:0];
    grp_pin[1] = port_a[7:4];
    grp_cfg[1] = pin_cfg_a[7:4];
    grp_pin[2] = port_b[6:3];
    grp_cfg[2] = pin_cfg_b[6:3];
    grp_pin[3] = {1'b1, port_b[2:0]};
    grp_cfg[3] = {1'b0, pin_cfg_b[2:0]};
  end

  // selected pin, with any low configured group pin pulling it low
  always_comb begin
    for (int n = 0; n < NLINE; n++) begin
      line_lvl[n] = grp_pin[n][q.pinsel[FIELD_W*n +: FIELD_W]]
        & (&(grp_pin[n] | ~grp_cfg[n]));
    end
  end

  // one detector per line
  genvar g;
  generate
    for (g = 0; g < NLINE; g++) begin : g_line
      ext_line_detect u_det (
        .clk_sys(clk_sys),
        .rst(rst),
        .level(line_lvl[g]),
        .sense(sense_e'(q.sense[FIELD_W*g +: FIELD_W])),
        .clr(line_clr[g]),
        .req(line_req[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  logic wr_sense; // accepted sensitivity write
  logic [13:0] wr_zero; // flags cleared by writing 0
  logic [13:0] seq_clr; // flags cleared by the access sequence
  logic [13:0] flag_clr; // all flag clears together
  logic [13:0] pending; // requests waiting, before the mask
  logic [13:0] active; // requests allowed by the mask
  logic ack_line; // ack hits an external line
  logic [3:0] ack_idx; // line index of the acked number

  always_comb begin
    wr_sense = reg_req.we & (reg_req.addr == ADDR_SENSE) & q.mask;
    for (int n = 0; n < NLINE; n++) begin
      sense_chg[n] = wr_sense
        & (reg_req.wdata[FIELD_W*n +: FIELD_W] != q.sense[FIELD_W*n +: FIELD_W]);
    end
    wr_zero = '0;
    if (reg_req.we && reg_req.addr == ADDR_STAT_LO) begin
      wr_zero[7:0] = ~reg_req.wdata;
    end
    if (reg_req.we && reg_req.addr == ADDR_STAT_HI) begin
      wr_zero[13:8] = ~reg_req.wdata[5:0];
    end
    // read or write of the associated register ends the sequence
    seq_clr = ((reg_req.we | reg_req.re) & (reg_req.addr == ADDR_ASSOC))
      ? q.armed : '0;
    flag_clr = wr_zero | seq_clr | periph_clr;
  end

  // ----------------------------------------------------------------
  // acknowledge and line clears
  // ----------------------------------------------------------------
  always_comb begin
    ack_idx = q.out.num - 4'(SRC_EXT0);
    ack_line = core_in.irq_ack & q.out.irq_req & ~q.out.is_trap
      & (q.out.num >= 4'(SRC_EXT0)) & (q.out.num < 4'(SRC_EXT0 + NLINE));
    for (int n = 0; n < NLINE; n++) begin
      line_clr[n] = sense_chg[n] | (ack_line & (ack_idx == 4'(n)));
    end
  end

  // ----------------------------------------------------------------
  // pending, priority and wakeup
  // ----------------------------------------------------------------
  logic found; // a maskable request won
  logic [3:0] win; // its number
  logic pb4_line2; // line2 routed to port b pin4

  always_comb begin
    // external lines carry no enable of their own
    pending = (q.flag & q.en & PERIPH_SRC)
      | ({10'h000, line_req} << SRC_EXT0);
    pending = pending & ~UNUSED_SRC;
    active = q.mask ? '0 : pending;
    found = 1'b0;
    win = 4'h0;
    // lowest number has the highest priority
    for (int n = NSRC - 1; n >= 0; n--) begin
      if (active[n]) begin
        found = 1'b1;
        win = 4'(n);
      end
    end
    pb4_line2 = (q.pinsel[FIELD_W*LINE2 +: FIELD_W] == LINE2_PB4_CODE);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;

    // sensitivity register, writable only under the mask
    if (wr_sense) begin
      d.sense = reg_req.wdata;
    end

    // pin selection; line3 keeps its field on the reserved code
    if (reg_req.we && reg_req.addr == ADDR_PINSEL) begin
      d.pinsel = reg_req.wdata;
      if (reg_req.wdata[FIELD_W*LINE3 +: FIELD_W] == LINE3_RSVD_CODE) begin
        d.pinsel[FIELD_W*LINE3 +: FIELD_W] = q.pinsel[FIELD_W*LINE3 +: FIELD_W];
      end
    end

    // peripheral enables
    if (reg_req.we && reg_req.addr == ADDR_EN_LO) begin
      d.en[7:0] = reg_req.wdata;
    end
    if (reg_req.we && reg_req.addr == ADDR_EN_HI) begin
      d.en[13:8] = reg_req.wdata[5:0];
    end

    // flags: a new event wins over any clear in the same cycle
    d.flag = (periph_set & PERIPH_SRC) | (q.flag & ~flag_clr);
    // a cleared flag drops its arming too
    d.armed = q.armed & ~flag_clr;
    if (reg_req.re && reg_req.addr == ADDR_STAT_LO) begin
      d.armed[7:0] = d.armed[7:0] | (q.flag[7:0] & ~flag_clr[7:0]);
    end
    if (reg_req.re && reg_req.addr == ADDR_STAT_HI) begin
      d.armed[13:8] = d.armed[13:8] | (q.flag[13:8] & ~flag_clr[13:8]);
    end

    // trap latch, cleared when its routine is entered
    if (core_in.trap_exec) begin
      d.trap = 1'b1;
    end else if (core_in.irq_ack && q.out.irq_req && q.out.is_trap) begin
      d.trap = 1'b0;
    end

    // global mask: entering a routine sets it
    if (core_in.irq_ack && q.out.irq_req) begin
      d.mask = 1'b1;
    end else if (core_in.mask_set) begin
      d.mask = 1'b1;
    end else if (core_in.mask_clr) begin
      d.mask = 1'b0;
    end

    // request towards the core; trap ignores the mask
    d.out.global_mask = d.mask;
    if (d.trap) begin
      d.out.irq_req = 1'b1;
      d.out.is_trap = 1'b1;
      d.out.num = 4'h0;
      d.out.vector = VEC_TRAP;
    end else begin
      d.out.irq_req = found & ~d.mask;
      d.out.is_trap = 1'b0;
      d.out.num = win;
      d.out.vector = VEC_SRC0 - {11'h000, win, 1'b0};
    end
    // an ack this cycle retires the request shown
    if (core_in.irq_ack && q.out.irq_req) begin
      d.out.irq_req = 1'b0;
    end

    // halt: lines (not pb4 on line2) and serial; auto wakeup only
    // in its own halt mode
    d.out.wake_halt = (core_in.halt_mode | core_in.auto_wakeup_halt_mode)
      & ((|(pending & HALT_WAKE
            & ~({11'h000, pb4_line2, 2'h0} << SRC_EXT0)))
        | (core_in.auto_wakeup_halt_mode & pending[SRC_AWU]));
    // active halt: reload overflow and primary_time_base only
    d.out.wake_active_halt = core_in.active_halt_mode
      & (|(pending & AHALT_WAKE));

    // read data, valid the cycle after the strobe
    d.rdata = 8'h00;
    if (reg_req.re) begin
      case (reg_req.addr)
        ADDR_SENSE: d.rdata = q.sense;
        ADDR_PINSEL: d.rdata = q.pinsel;
        ADDR_EN_LO: d.rdata = q.en[7:0];
        ADDR_EN_HI: d.rdata = {2'h0, q.en[13:8]};
        ADDR_STAT_LO: d.rdata = q.flag[7:0];
        ADDR_STAT_HI: d.rdata = {2'h0, q.flag[13:8]};
        ADDR_ASSOC: d.rdata = 8'h00;
        ADDR_CORE: d.rdata = {q.mask, q.trap, q.out.irq_req, 1'b0, q.out.num};
        default: d.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q.sense <= SENSE_RST;
      q.pinsel <= PINSEL_RST;
      q.en <= EN_RST;
      q.flag <= '0;
      q.armed <= '0;
      q.trap <= 1'b0;
      q.mask <= MASK_RST;
      q.rdata <= 8'h00;
      q.out <= '{irq_req: 1'b0, is_trap: 1'b0, num: 4'h0,
                 vector: VEC_RESET, global_mask: MASK_RST,
                 wake_halt: 1'b0, wake_active_halt: 1'b0};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, straight from flip-flops
  // ----------------------------------------------------------------
  assign rdata = q.rdata;
  assign core_out = q.out;

endmodule : irq_ctrl

// *** logic/ic_pkg.sv ***
// package of the interrupt controller: register map, field layout,
// reset values, source numbers, vectors and the carrier structs.
// assumes an 8-bit register port and a core that acknowledges the
// request it sees on the same cycle.
package ic_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NSRC = 14; // maskable source numbers 0..13
  localparam int NLINE = 4; // external lines
  localparam int FIELD_W = 2; // width of a per-line field

  // ----------------------------------------------------------------
  // register indices on the 3-bit register port
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_SENSE = 3'h0; // ext_irq_sense_ctrl
  localparam logic [2:0] ADDR_PINSEL = 3'h1; // ext_irq_pin_select
  localparam logic [2:0] ADDR_EN_LO = 3'h2; // enables 7:0
  localparam logic [2:0] ADDR_EN_HI = 3'h3; // enables 13:8
  localparam logic [2:0] ADDR_STAT_LO = 3'h4; // flags 7:0
  localparam logic [2:0] ADDR_STAT_HI = 3'h5; // flags 13:8
  localparam logic [2:0] ADDR_ASSOC = 3'h6; // associated register
  localparam logic [2:0] ADDR_CORE = 3'h7; // controller state

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SENSE_RST = 8'h00;
  localparam logic [7:0] PINSEL_RST = 8'h0c;
  localparam logic [13:0] EN_RST = 14'h0000;
  localparam logic MASK_RST = 1'b1; // global mask set after reset

  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] LINE2_PB4_CODE = 2'h1; // no halt wakeup
  localparam logic [1:0] LINE3_RSVD_CODE = 2'h3; // reserved selection
  localparam int LINE2 = 2;
  localparam int LINE3 = 3;

  // sensitivity codes of one field
  typedef enum logic [1:0] {
    SENSE_FALL_LOW = 2'b00,
    SENSE_RISE = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_BOTH = 2'b11
  } sense_e;

  // ----------------------------------------------------------------
  // source sets and vectors
  // ----------------------------------------------------------------
  localparam int SRC_AWU = 0; // auto_wakeup_source
  localparam int SRC_EXT0 = 1; // ext_line_0, lines follow upward
  localparam logic [13:0] PERIPH_SRC = 14'h1fa1; // 0,5,7..12
  localparam logic [13:0] UNUSED_SRC = 14'h2040; // 6 and 13
  localparam logic [13:0] HALT_WAKE = 14'h101e; // lines and spi
  localparam logic [13:0] AHALT_WAKE = 14'h0a00; // reload ovf, primary_time_base
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TRAP = 16'hfffc;
  localparam logic [15:0] VEC_SRC0 = 16'hfffa;

  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } reg_req_s;

  // events and modes from the core
  typedef struct packed {
    logic trap_exec; // trap instruction executed, pulse
    logic irq_ack; // core enters the presented routine, pulse
    logic mask_set; // core sets the global mask, pulse
    logic mask_clr; // core clears the global mask, pulse
    logic halt_mode; // level
    logic active_halt_mode; // level
    logic auto_wakeup_halt_mode; // level
  } core_in_s;

  // request and wakeup towards the core
  typedef struct packed {
    logic irq_req;
    logic is_trap;
    logic [3:0] num;
    logic [15:0] vector;
    logic global_mask;
    logic wake_halt;
    logic wake_active_halt;
  } core_out_s;

endpackage : ic_pkg

// *** logic/ext_line_detect.sv ***
// one external interrupt line: edge detection, pending latch and
// level request.
// assumes the line level is synchronous to clk_sys and idles high.
`timescale 1ns/100ps
module ext_line_detect (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // line
  input wire level,
  input ic_pkg::sense_e sense,
  input wire clr,
  // request
  output logic req
);
  import ic_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic prev; // level one cycle ago
    logic pend; // latched edge
    logic req; // request out
  } line_s;

  line_s q;
  line_s d;
  logic ev; // edge of the selected kind

  // next state
  always_comb begin
    d = q;
    ev = 1'b0;
    case (sense)
      SENSE_FALL_LOW: ev = q.prev & ~level;
      SENSE_RISE: ev = ~q.prev & level;
      SENSE_FALL: ev = q.prev & ~level;
      SENSE_BOTH: ev = q.prev ^ level;
      default: ev = 1'b0;
    endcase
    d.prev = level;
    // new edge wins over a clear in the same cycle
    d.pend = ev | (q.pend & ~clr);
    d.req = d.pend | ((sense == SENSE_FALL_LOW) & ~level);
  end

  // registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '{prev: 1'b1, pend: 1'b0, req: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign req = q.req;

endmodule : ext_line_detect

// *** test/irq_ctrl_assertions.sv ***
// checker of irq_ctrl: sees only the top module ports.
// assumes one clock, clk_sys, and the asynchronous reset rst.
`timescale 1ns/100ps
module irq_ctrl_checker (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // register port
  input ic_pkg::reg_req_s reg_req,
  input wire [7:0] rdata,
  // processor core
  input ic_pkg::core_in_s core_in,
  input ic_pkg::core_out_s core_out,
  // pins and flags
  input wire [7:0] port_a,
  input wire [6:0] port_b,
  input wire [7:0] pin_cfg_a,
  input wire [6:0] pin_cfg_b,
  input wire [13:0] periph_set,
  input wire [13:0] periph_clr
);
  import ic_pkg::*;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // trap shows its vector one cycle later, mask or not
  a_trap_vector: assert property (core_in.trap_exec && !core_in.irq_ack |=>
    core_out.irq_req && core_out.is_trap && core_out.vector == VEC_TRAP)
    else $error("trap not presented");
  // maskable vector follows its number
  a_vector_pairs: assert property (core_out.irq_req && !core_out.is_trap |->
    core_out.vector == VEC_SRC0 - {11'h000, core_out.num, 1'b0})
    else $error("vector does not match number");
  // maskable requests only with the mask clear
  a_mask_gates: assert property (core_out.irq_req && !core_out.is_trap |->
    !core_out.global_mask) else $error("request while masked");
  // entering a routine sets the mask
  a_ack_sets_mask: assert property (core_in.irq_ack && core_out.irq_req |=>
    core_out.global_mask) else $error("mask not set on entry");
  // mask set straight out of reset
  a_reset_mask: assert property ($past(rst) |-> core_out.global_mask)
    else $error("mask clear after reset");
  // unused numbers never requested
  a_unused_nums: assert property (core_out.irq_req |->
    core_out.num != 4'h6 && core_out.num != 4'hd) else $error("unused number");
  // read data only in the cycle after a read
  a_rdata_idle: assert property (!$past(reg_req.re) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  // halt wakeup only while halted
  a_wake_halt: assert property (core_out.wake_halt |->
    $past(core_in.halt_mode) || $past(core_in.auto_wakeup_halt_mode))
    else $error("halt wakeup outside halt");
  // active halt wakeup only while in active halt
  a_wake_ahalt: assert property (core_out.wake_active_halt |->
    $past(core_in.active_halt_mode)) else $error("active halt wakeup outside mode");
endmodule : irq_ctrl_checker

bind irq_ctrl irq_ctrl_checker irq_ctrl_checker_inst (.clk_sys(clk_sys), .rst(rst),
  .reg_req(reg_req), .rdata(rdata), .core_in(core_in), .core_out(core_out),
  .port_a(port_a), .port_b(port_b), .pin_cfg_a(pin_cfg_a), .pin_cfg_b(pin_cfg_b),
  .periph_set(periph_set), .periph_clr(periph_clr));

// *** test/core_partner.sv ***
// model of the processor core: acks each shown request after a delay.
// assumes registered request outputs of irq_ctrl on clk_sys.
`timescale 1ns/100ps
module core_partner (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // request side
  input ic_pkg::core_out_s core_out,
  input wire [3:0] ack_dly,
  // answer side
  output logic irq_ack,
  output logic [15:0] taken_vec,
  output logic [7:0] acks
);
  import ic_pkg::*;
  logic [3:0] wait_q; // cycles spent on the shown request
  // finish the instruction, stack, then enter the routine
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_ack <= 1'b0;
      wait_q <= 4'h0;
      taken_vec <= 16'h0000;
      acks <= 8'h00;
    end else if (irq_ack) begin
      // one pulse; the request drops after it
      irq_ack <= 1'b0;
      wait_q <= 4'h0;
    end else if (core_out.irq_req && wait_q == ack_dly) begin
      irq_ack <= 1'b1;
      taken_vec <= core_out.vector;
      acks <= acks + 8'h01;
    end else if (core_out.irq_req) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : core_partner

// *** test/irq_ctrl_test.sv ***
// testbench of irq_ctrl with a core partner, pins and peripheral flags.
// assumes ic_pkg, irq_ctrl and core_partner are compiled first.
`timescale 1ns/100ps
module irq_ctrl_test;
  import ic_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_sys, rst, we, re, trap, ack, mset, mclr, halt, ahalt, auto_wakeup_source;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, port_a, acks, cfg_a;
  logic [6:0] port_b;
  logic [13:0] pset;
  logic [3:0] ack_dly;
  logic [15:0] taken_vec;
  reg_req_s reg_req;
  core_in_s core_in;
  core_out_s core_out;
  int fails, num_checks, exp_acks;
  assign reg_req = {addr, wdata, we, re};
  assign core_in = {trap, ack, mset, mclr, halt, ahalt, auto_wakeup_source};
  irq_ctrl irq_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req), .rdata(rdata),
    .core_in(core_in), .core_out(core_out), .port_a(port_a), .port_b(port_b),
    .pin_cfg_a(cfg_a), .pin_cfg_b(7'h00), .periph_set(pset), .periph_clr(14'h0000));
  core_partner core_partner_inst (.clk_sys(clk_sys), .rst(rst), .core_out(core_out),
    .ack_dly(ack_dly), .irq_ack(ack), .taken_vec(taken_vec), .acks(acks));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  task chk(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
      fails++;
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    we <= 1'b0;
  endtask : wr
  // read data is judged in the cycle after the strobe
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    re <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    re <= 1'b0;
    #1;
    chk({24'h0, e}, {24'h0, rdata});
  endtask : rd
  task setmask(input logic m);
    @(posedge clk_sys);
    mset <= m;
    mclr <= ~m;
    @(posedge clk_sys);
    mset <= 1'b0;
    mclr <= 1'b0;
  endtask : setmask
  task fire(input logic [13:0] v);
    @(posedge clk_sys);
    pset <= v;
    @(posedge clk_sys);
    pset <= 14'h0000;
  endtask : fire
  task pins(input logic [7:0] a, input logic [6:0] b);
    @(posedge clk_sys);
    port_a <= a;
    port_b <= b;
    repeat (3) @(posedge clk_sys);
  endtask : pins
  // next ack of the partner, bounded, and the vector it fetched
  task wait_ack(input logic [15:0] v);
    int n;
    n = 0;
    while (acks == exp_acks[7:0] && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    // a partner that never acks is a mismatch of its own
    if (n >= 40) begin
      $display("FAIL t=%0t exp=%h got=%h", $time, exp_acks + 1, acks);
      fails++;
    end
    exp_acks++;
    chk({16'h0, v}, {16'h0, taken_vec});
  endtask : wait_ack
  // no routine entered over eight cycles
  task none();
    repeat (8) @(posedge clk_sys);
    chk(exp_acks, {24'h0, acks});
  endtask : none
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset();
    #1;
    chk(32'h0000fffe, {16'h0, core_out.vector});
    rd(ADDR_SENSE, 8'h00);
    rd(ADDR_PINSEL, 8'h0c);
    rd(ADDR_CORE, 8'h80);
    $display("reset values finished");
  endtask : t_reset
  task t_sense();
    setmask(1'b0);
    wr(ADDR_SENSE, 8'hff);
    rd(ADDR_SENSE, 8'h00);
    setmask(1'b1);
    wr(ADDR_SENSE, 8'he4);
    rd(ADDR_SENSE, 8'he4);
    $display("sensitivity lock finished");
  endtask : t_sense
  task t_trap();
    ack_dly <= 4'h5;
    @(posedge clk_sys);
    trap <= 1'b1;
    @(posedge clk_sys);
    trap <= 1'b0;
    wait_ack(VEC_TRAP);
    ack_dly <= 4'h0;
    $display("trap finished");
  endtask : t_trap
  task t_edge();
    pins(8'h7f, 7'h7f);
    pins(8'hff, 7'h7f);
    none();
    setmask(1'b0);
    wait_ack(16'hfff6);
    setmask(1'b0);
    none();
    // set the global mask again so the sense write is accepted and drops the latched edge
    setmask(1'b1);
    pins(8'h7f, 7'h7f);
    pins(8'hff, 7'h7f);
    wr(ADDR_SENSE, 8'hec);
    setmask(1'b0);
    none();
    setmask(1'b1);
    $display("external edge finished");
  endtask : t_edge
  task t_priority();
    wr(ADDR_EN_LO, 8'h80);
    wr(ADDR_EN_HI, 8'h10);
    setmask(1'b0);
    fire(14'h1080);
    wait_ack(16'hffec);
    wr(ADDR_STAT_LO, 8'h00);
    setmask(1'b0);
    wait_ack(16'hffe2);
    rd(ADDR_STAT_HI, 8'h10);
    rd(ADDR_ASSOC, 8'h00);
    rd(ADDR_STAT_HI, 8'h00);
    $display("priority finished");
  endtask : t_priority
  task t_discard();
    setmask(1'b0);
    fire(14'h0020);
    none();
    rd(ADDR_STAT_LO, 8'h20);
    rd(ADDR_ASSOC, 8'h00);
    wr(ADDR_EN_LO, 8'ha0);
    none();
    rd(ADDR_STAT_LO, 8'h00);
    setmask(1'b1);
    $display("pending discard finished");
  endtask : t_discard
  task t_wake();
    wr(ADDR_EN_HI, 8'h12);
    fire(14'h0080);
    halt <= 1'b1;
    pins(8'hff, 7'h7f);
    chk(32'h0, {31'h0, core_out.wake_halt});
    fire(14'h1000);
    pins(8'hff, 7'h7f);
    chk(32'h1, {31'h0, core_out.wake_halt});
    halt <= 1'b0;
    ahalt <= 1'b1;
    pins(8'hff, 7'h7f);
    chk(32'h0, {31'h0, core_out.wake_active_halt});
    fire(14'h0200);
    pins(8'hff, 7'h7f);
    chk(32'h1, {31'h0, core_out.wake_active_halt});
    ahalt <= 1'b0;
    wr(ADDR_STAT_LO, 8'h00);
    wr(ADDR_STAT_HI, 8'h00);
    $display("wakeup finished");
  endtask : t_wake
  task t_pinsel();
    wr(ADDR_PINSEL, 8'h5b);
    rd(ADDR_PINSEL, 8'h5b);
    wr(ADDR_PINSEL, 8'hdb);
    rd(ADDR_PINSEL, 8'h5b);
    halt <= 1'b1;
    pins(8'hff, 7'h6f);
    chk(32'h0, {31'h0, core_out.wake_halt});
    halt <= 1'b0;
    setmask(1'b0);
    wait_ack(16'hfff4);
    pins(8'hff, 7'h6d);
    setmask(1'b0);
    wait_ack(16'hfff2);
    // line0 on pa3 with pa0 configured as input and low: level request
    cfg_a <= 8'h01;
    pins(8'hfe, 7'h6d);
    setmask(1'b0);
    wait_ack(16'hfff8);
    $display("pin selection finished");
  endtask : t_pinsel
  // ----------------------------------------------------------------
  // clock, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    {rst, we, re, trap, mset, mclr, halt, ahalt, auto_wakeup_source} = 9'h100;
    {addr, wdata, pset, ack_dly} = '0;
    port_a = 8'hff;
    cfg_a = 8'h00;
    port_b = 7'h7f;
    {fails, num_checks, exp_acks} = '0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_sense();
    t_trap();
    t_edge();
    t_priority();
    t_discard();
    t_wake();
    t_pinsel();
    summarize();
  end
  // the run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    summarize();
  end
endmodule : irq_ctrl_test
